// ---- hw/dsp_defines.vh ----
// Register addresses, field positions and divider constants for the serial port pair
`ifndef DSP_DEFINES_VH
`define DSP_DEFINES_VH

// ----------------------------------------------------------------------------
// Special-function register addresses
// ----------------------------------------------------------------------------
`define DSP_ADDR_PRI_CTRL 8'h98
`define DSP_ADDR_PRI_BUF 8'h99
`define DSP_ADDR_OPT_CTRL 8'h9b
`define DSP_ADDR_OPT_BUF 8'h9c
`define DSP_ADDR_POWER_CTRL 8'h87
`define DSP_ADDR_BAUD_SRC 8'hd8
`define DSP_ADDR_PRI_REL_LO 8'haa
`define DSP_ADDR_PRI_REL_HI 8'hba
`define DSP_ADDR_OPT_REL_LO 8'h9d
`define DSP_ADDR_OPT_REL_HI 8'h9e

// ----------------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------------
`define DSP_CTL_MODE_HI 7
`define DSP_CTL_MODE_LO 6
`define DSP_CTL_MPROC 5
`define DSP_CTL_REN 4
`define DSP_CTL_TX9 3
`define DSP_CTL_RX9 2
`define DSP_CTL_TXDONE 1
`define DSP_CTL_RXDONE 0
`define DSP_DOUBLE_BIT 7
`define DSP_BAUD_SRC_BIT 7

// ----------------------------------------------------------------------------
// Reset values and divider constants
// ----------------------------------------------------------------------------
`define DSP_CTRL_RESET 8'h00
`define DSP_RELOAD_RESET 10'h000
`define DSP_RELOAD_TOP 10'h3ff
`define DSP_PRE_PRI_NORMAL 2'h3
`define DSP_PRE_PRI_DOUBLE 2'h1
`define DSP_PRE_OPT 2'h1
`define DSP_OVERSAMPLE_LAST 4'hf
`define DSP_START_MID 4'h7
`define DSP_BITS_8 4'ha
`define DSP_BITS_9 4'hb

`endif

// ---- hw/dsp_uart_chan.v ----
// One full-duplex serial channel: transmitter and 16x oversampling receiver
`timescale 1ns/1ps

module dsp_uart_chan (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Timing and configuration
    input wire i_tick,
    input wire i_enable,
    input wire i_nine_bit,
    input wire i_tx_ninth,
    input wire i_multiproc,
    input wire i_rx_enable,
    // Transmit request
    input wire i_tx_start,
    input wire [7:0] i_tx_data,
    // Receive line, already synchronised
    input wire i_rxd,
    // Results
    output reg o_txd,
    output reg o_tx_done,
    output reg o_rx_done,
    output reg [7:0] o_rx_data,
    output reg o_rx_ninth
);

`include "dsp_defines.vh"

    // ------------------------------------------------------------------------
    // Receiver states
    // ------------------------------------------------------------------------
    localparam RX_IDLE = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA = 2'b10;
    localparam RX_STOP = 2'b11;

    reg [10:0] tx_shift_q; // Frame bits, sent from bit 0 upward
    reg [3:0] tx_bits_q; // Bits still to send
    reg [3:0] tx_phase_q; // Oversample phase of current bit
    reg tx_busy_q; // Frame in flight
    reg [1:0] rx_state_q; // Receiver state
    reg [3:0] rx_phase_q; // Oversample phase
    reg [3:0] rx_cnt_q; // Data bits taken
    reg [8:0] rx_shift_q; // Bits enter at the top

    // ------------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------------
    // Loads a frame on a buffer write and sends it, idle line high
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_shift_q <= 11'h7ff;
            tx_bits_q <= 4'h0;
            tx_phase_q <= 4'h0;
            tx_busy_q <= 1'b0;
            o_txd <= 1'b1;
            o_tx_done <= 1'b0;
        end else begin
            o_tx_done <= 1'b0;
            if (!tx_busy_q) begin
                // Buffer write launches a frame only when the channel is enabled
                if (i_tx_start && i_enable) begin
                    // Start, data LSB first, ninth bit or stop, stop
                    tx_shift_q <= {1'b1, (i_nine_bit ? i_tx_ninth : 1'b1), i_tx_data, 1'b0};
                    tx_bits_q <= i_nine_bit ? `DSP_BITS_9 : `DSP_BITS_8;
                    tx_phase_q <= 4'h0;
                    tx_busy_q <= 1'b1;
                end
            end else if (i_tick) begin
                tx_phase_q <= tx_phase_q + 4'h1;
                if (tx_phase_q == 4'h0) begin
                    if (tx_bits_q == 4'h0) begin
                        // Stop bit has had its full time
                        tx_busy_q <= 1'b0;
                        o_tx_done <= 1'b1;
                    end else begin
                        o_txd <= tx_shift_q[0];
                        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                        tx_bits_q <= tx_bits_q - 4'h1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------------
    // Runs beside the transmitter so both directions work at once
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_state_q <= RX_IDLE;
            rx_phase_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            rx_shift_q <= 9'h000;
            o_rx_done <= 1'b0;
            o_rx_data <= 8'h00;
            o_rx_ninth <= 1'b0;
        end else begin
            o_rx_done <= 1'b0;
            if (!i_rx_enable || !i_enable) begin
                // Reception only while enabled
                rx_state_q <= RX_IDLE;
            end else if (i_tick) begin
                rx_phase_q <= rx_phase_q + 4'h1;
                case (rx_state_q)
                    RX_IDLE: begin
                        // Low level marks a start bit
                        if (!i_rxd) begin
                            rx_state_q <= RX_START;
                            rx_phase_q <= 4'h0;
                        end
                    end
                    RX_START: begin
                        // Confirm start at its centre, else a glitch
                        if (rx_phase_q == `DSP_START_MID) begin
                            rx_phase_q <= 4'h0;
                            rx_cnt_q <= 4'h0;
                            rx_state_q <= i_rxd ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        // Sample at bit centre, LSB arrives first
                        if (rx_phase_q == `DSP_OVERSAMPLE_LAST) begin
                            rx_shift_q <= {i_rxd, rx_shift_q[8:1]};
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q == (i_nine_bit ? 4'h8 : 4'h7)) begin
                                rx_state_q <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (rx_phase_q == `DSP_OVERSAMPLE_LAST) begin
                            rx_state_q <= RX_IDLE;
                            // Low stop is a framing fault and stores nothing
                            if (i_rxd) begin
                                if (i_nine_bit) begin
                                    // Multiprocessor: only ninth bit one is taken
                                    if (!i_multiproc || rx_shift_q[8]) begin
                                        o_rx_data <= rx_shift_q[7:0];
                                        o_rx_ninth <= rx_shift_q[8];
                                        o_rx_done <= 1'b1;
                                    end
                                end else begin
                                    o_rx_data <= rx_shift_q[8:1];
                                    o_rx_ninth <= i_rxd; // Stop bit in 8-bit mode
                                    o_rx_done <= 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        rx_state_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ---- hw/dsp_serial_pair.v ----
// Two serial ports on the special-function register bus, with baud generators
//
// Overview of operation
// - Bytes travel least significant bit first.
// - Buffer write transmits; read gives received byte.
// - Writing the buffer starts transmission.
// - Ports run independently and full duplex.
// - Source bit picks timer or internal generator.
// - Timer rate: 2^double*clk/(384*(256-high byte)).
// - Internal rates use 64 or 32 divider.
// - Reload is ten bits from two bytes.
// - Rates from 300 to 38400 supported.
// - Parity, stops, flow control done via ninth bit.
// - Primary mode bits choose frame format.
// - Modes 1 and 3 use variable rate.
// - Mode 2 runs at clock/32 or /64.
// - Optical port: 9-bit or 8-bit, internal timing.
// - Ninth transmitted bit comes from control bit.
// - Multiprocessor mode flags only ninth-bit-one frames in 9-bit modes.
// - Hardware sets done flags; software clears them.
// - Written ones never set done flags.
// - Reception needs receive enable set.
// - Doubling bit doubles primary variable rate.
`timescale 1ns/1ps

module dsp_serial_pair (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Special-function register bus
    input wire [7:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    input wire i_sfr_wr,
    output reg [7:0] o_sfr_rdata,
    // Timer 1 overflow pulse, same clock
    input wire i_timer_one_overflow,
    // Primary serial port pins
    input wire i_primary_rxd,
    output wire o_primary_txd,
    // Optical serial port pins
    input wire i_optical_rxd,
    output wire o_optical_txd
);

`include "dsp_defines.vh"

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg [7:0] ctrl_q [0:1]; // Control registers, 0 primary, 1 optical
    reg [9:0] reload_q [0:1]; // Ten-bit reload values
    reg [7:0] tx_data_q [0:1]; // Transmit byte for the channel
    reg [1:0] tx_start_q; // One-cycle launch pulses
    reg double_q; // Baud doubling bit
    reg baud_src_q; // 1 = internal generator
    reg [1:0] sync1_q; // First synchroniser stage
    reg [1:0] sync2_q; // Second synchroniser stage
    reg timer_half_q; // Halves timer overflows when not doubled

    // ------------------------------------------------------------------------
    // Channel-facing wires
    // ------------------------------------------------------------------------
    wire [1:0] tick; // 16x oversample ticks
    wire [1:0] enable; // Channel usable in current mode
    wire [1:0] nine_bit; // Nine data bits per frame
    wire [1:0] txd; // Serial outputs
    wire [1:0] tx_done; // Frame sent pulses
    wire [1:0] rx_done; // Frame received pulses
    wire [1:0] rx_ninth; // Received ninth bits
    wire [7:0] rx_data [0:1]; // Received bytes
    wire [1:0] pri_mode; // Primary mode bits
    wire pri_fixed; // Primary mode 2
    wire pri_timer; // Primary driven by timer 1

    assign pri_mode = ctrl_q[0][`DSP_CTL_MODE_HI:`DSP_CTL_MODE_LO];
    // Mode 00 unsupported, mode 01 8-bit, 10 and 11 9-bit
    assign enable[0] = (pri_mode != 2'b00);
    assign nine_bit[0] = pri_mode[1];
    assign pri_fixed = (pri_mode == 2'b10);
    // Timer only for variable modes with source bit clear
    assign pri_timer = !baud_src_q && !pri_fixed;
    // Optical: mode bit 0 is 9-bit, 1 is 8-bit
    assign enable[1] = 1'b1;
    assign nine_bit[1] = !ctrl_q[1][`DSP_CTL_MODE_HI];
    assign o_primary_txd = txd[0];
    assign o_optical_txd = txd[1];

    // ------------------------------------------------------------------------
    // Write decode helper
    // ------------------------------------------------------------------------
    // Flag update: hardware set wins, a written zero clears
    function flag_next;
        input cur;
        input hw_set;
        input wr;
        input wbit;
        begin
            flag_next = hw_set | (cur & ~(wr & ~wbit));
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Receive pins cross in from outside; two flops before use
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= 2'b11;
            sync2_q <= 2'b11;
        end else begin
            sync1_q <= {i_optical_rxd, i_primary_rxd};
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------------------
    // Port-wide registers
    // ------------------------------------------------------------------------
    // Doubling and source bits, launch pulses
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            double_q <= 1'b0;
            baud_src_q <= 1'b0;
            tx_start_q <= 2'b00;
        end else begin
            tx_start_q <= 2'b00;
            if (i_sfr_wr) begin
                case (i_sfr_addr)
                    `DSP_ADDR_POWER_CTRL: begin
                        double_q <= i_sfr_wdata[`DSP_DOUBLE_BIT];
                    end
                    `DSP_ADDR_BAUD_SRC: begin
                        baud_src_q <= i_sfr_wdata[`DSP_BAUD_SRC_BIT];
                    end
                    `DSP_ADDR_PRI_BUF: begin
                        tx_start_q[0] <= 1'b1;
                    end
                    `DSP_ADDR_OPT_BUF: begin
                        tx_start_q[1] <= 1'b1;
                    end
                    default: begin
                        tx_start_q <= 2'b00;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Timer 1 path for the primary port
    // ------------------------------------------------------------------------
    // Overflow is clk/(12*(256-high byte)); 16x tick needs half that, or all when doubled
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_half_q <= 1'b0;
        end else if (i_timer_one_overflow) begin
            timer_half_q <= ~timer_half_q;
        end
    end

    // ------------------------------------------------------------------------
    // Per-port registers, baud generators and channels
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
            localparam [7:0] A_CTRL = (gi == 0) ? `DSP_ADDR_PRI_CTRL : `DSP_ADDR_OPT_CTRL;
            localparam [7:0] A_BUF = (gi == 0) ? `DSP_ADDR_PRI_BUF : `DSP_ADDR_OPT_BUF;
            localparam [7:0] A_RLO = (gi == 0) ? `DSP_ADDR_PRI_REL_LO : `DSP_ADDR_OPT_REL_LO;
            localparam [7:0] A_RHI = (gi == 0) ? `DSP_ADDR_PRI_REL_HI : `DSP_ADDR_OPT_REL_HI;

            reg [1:0] pre_q; // Prescaler
            reg [9:0] cnt_q; // Reload counter
            reg gen_tick_q; // Internal generator tick
            wire [1:0] pre_last; // Prescaler terminal value
            wire [9:0] rel_eff; // Reload used by the counter
            wire wr_ctrl; // Control register write
            wire [7:0] c; // Current control value

            assign c = ctrl_q[gi];
            assign wr_ctrl = i_sfr_wr && (i_sfr_addr == A_CTRL);
            // Primary divides by 4, or 2 doubled; optical always by 2
            assign pre_last = (gi == 0) ? (double_q ? `DSP_PRE_PRI_DOUBLE : `DSP_PRE_PRI_NORMAL)
                                        : `DSP_PRE_OPT;
            // Mode 2 forces one count so rate is clk/32 or clk/64
            assign rel_eff = (gi == 0 && pri_fixed) ? `DSP_RELOAD_TOP : reload_q[gi];

            // Internal generator: prescale then count reload up to 1023
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pre_q <= 2'h0;
                    cnt_q <= `DSP_RELOAD_RESET;
                    gen_tick_q <= 1'b0;
                end else begin
                    gen_tick_q <= 1'b0;
                    if (pre_q >= pre_last) begin
                        pre_q <= 2'h0;
                        if (cnt_q == `DSP_RELOAD_TOP) begin
                            cnt_q <= rel_eff;
                            gen_tick_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 10'h001;
                        end
                    end else begin
                        pre_q <= pre_q + 2'h1;
                    end
                end
            end

            // Timer 1 source exists on the primary port only
            if (gi == 0) begin : g_pri_tick
                assign tick[gi] = pri_timer ? (i_timer_one_overflow && (double_q || timer_half_q)) : gen_tick_q;
            end else begin : g_opt_tick
                assign tick[gi] = gen_tick_q;
            end

            // Control, reload and transmit byte registers
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ctrl_q[gi] <= `DSP_CTRL_RESET;
                    reload_q[gi] <= `DSP_RELOAD_RESET;
                    tx_data_q[gi] <= 8'h00;
                end else begin
                    // Plain control fields
                    if (wr_ctrl) begin
                        ctrl_q[gi][7:3] <= (gi == 0) ? i_sfr_wdata[7:3] : {i_sfr_wdata[7], 1'b0, i_sfr_wdata[5:3]};
                    end
                    // Received ninth bit: hardware load wins over software
                    if (rx_done[gi]) begin
                        ctrl_q[gi][`DSP_CTL_RX9] <= rx_ninth[gi];
                    end else if (wr_ctrl) begin
                        ctrl_q[gi][`DSP_CTL_RX9] <= i_sfr_wdata[`DSP_CTL_RX9];
                    end
                    // Done flags
                    ctrl_q[gi][`DSP_CTL_TXDONE] <= flag_next(c[`DSP_CTL_TXDONE], tx_done[gi], wr_ctrl,
                                                             i_sfr_wdata[`DSP_CTL_TXDONE]);
                    ctrl_q[gi][`DSP_CTL_RXDONE] <= flag_next(c[`DSP_CTL_RXDONE], rx_done[gi], wr_ctrl,
                                                             i_sfr_wdata[`DSP_CTL_RXDONE]);
                    // Ten-bit reload from low byte and two high bits
                    if (i_sfr_wr && i_sfr_addr == A_RLO) begin
                        reload_q[gi][7:0] <= i_sfr_wdata;
                    end
                    if (i_sfr_wr && i_sfr_addr == A_RHI) begin
                        reload_q[gi][9:8] <= i_sfr_wdata[1:0];
                    end
                    // Transmit side of the shared buffer
                    if (i_sfr_wr && i_sfr_addr == A_BUF) begin
                        tx_data_q[gi] <= i_sfr_wdata;
                    end
                end
            end

            // Serial engine of this port
            dsp_uart_chan u_chan (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_tick(tick[gi]),
                .i_enable(enable[gi]),
                .i_nine_bit(nine_bit[gi]),
                .i_tx_ninth(c[`DSP_CTL_TX9]),
                .i_multiproc(c[`DSP_CTL_MPROC]),
                .i_rx_enable(c[`DSP_CTL_REN]),
                .i_tx_start(tx_start_q[gi]),
                .i_tx_data(tx_data_q[gi]),
                .i_rxd(sync2_q[gi]),
                .o_txd(txd[gi]),
                .o_tx_done(tx_done[gi]),
                .o_rx_done(rx_done[gi]),
                .o_rx_data(rx_data[gi]),
                .o_rx_ninth(rx_ninth[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Registered read mux; unmapped addresses read zero
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sfr_rdata <= 8'h00;
        end else begin
            case (i_sfr_addr)
                `DSP_ADDR_PRI_CTRL: o_sfr_rdata <= ctrl_q[0];
                `DSP_ADDR_OPT_CTRL: o_sfr_rdata <= ctrl_q[1];
                `DSP_ADDR_PRI_BUF: o_sfr_rdata <= rx_data[0];
                `DSP_ADDR_OPT_BUF: o_sfr_rdata <= rx_data[1];
                `DSP_ADDR_POWER_CTRL: o_sfr_rdata <= {double_q, 7'h00};
                `DSP_ADDR_BAUD_SRC: o_sfr_rdata <= {baud_src_q, 7'h00};
                `DSP_ADDR_PRI_REL_LO: o_sfr_rdata <= reload_q[0][7:0];
                `DSP_ADDR_PRI_REL_HI: o_sfr_rdata <= {6'h00, reload_q[0][9:8]};
                `DSP_ADDR_OPT_REL_LO: o_sfr_rdata <= reload_q[1][7:0];
                `DSP_ADDR_OPT_REL_HI: o_sfr_rdata <= {6'h00, reload_q[1][9:8]};
                default: o_sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// ---- tb/dsp_host_model.sv ----
// Far-end serial host: frame sender and decoder
`timescale 1ns/1ps
module dsp_host_model (
    input wire i_line,
    output reg o_line
);
    initial o_line = 1'b1; // Idle high
    // Start, data LSB first, optional ninth, stop
    task send(input [7:0] d, input b9, input nine, input stp, input integer per);
        integer k;
        begin
            o_line = 1'b0;
            #(per);
            for (k = 0; k < 8 + nine; k = k + 1) begin
                o_line = k < 8 ? d[k] : b9;
                #(per);
            end
            o_line = stp;
            #(per);
            o_line = 1'b1;
        end
    endtask
    // Mid-bit sampling; last sampled bit holds stop
    task recv(input nine, input integer per, output [9:0] v);
        integer k;
        begin
            v = 10'h000;
            @(negedge i_line);
            #(per + per / 2);
            for (k = 0; k < 9 + nine; k = k + 1) begin
                v[k] = i_line;
                #(per);
            end
        end
    endtask
endmodule

// ---- tb/dsp_pair_props.sv ----
// Port assertions for the serial port pair
`timescale 1ns/1ps
module dsp_pair_props (
    input wire i_clk, i_rst_n, i_sfr_wr, i_timer_one_overflow,
    input wire [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata,
    input wire i_primary_rxd, o_primary_txd, i_optical_rxd, o_optical_txd
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_txd_reset_high: assert property ($rose(i_rst_n) |-> o_primary_txd && o_optical_txd)
        else $error("txd low at reset");
    a_unmapped_zero: assert property (i_sfr_addr == 8'h01 |=> o_sfr_rdata == 8'h00)
        else $error("unmapped not zero");
    a_ctrl_readback: assert property (i_sfr_wr && i_sfr_addr == 8'h98 ##1 i_sfr_addr == 8'h98
        |=> o_sfr_rdata[7:3] == $past(i_sfr_wdata[7:3], 2)) else $error("ctrl not stored");
    a_flag_clear: assert property (i_sfr_wr && i_sfr_addr == 8'h98 && i_sfr_wdata[1:0] == 2'b00
        ##1 i_sfr_addr == 8'h98 |=> o_sfr_rdata[1:0] == 2'b00) else $error("flag not cleared");
    a_opt_bit6_zero: assert property (i_sfr_addr == 8'h9b |=> !o_sfr_rdata[6])
        else $error("bit six set");
    a_source_readback: assert property (i_sfr_wr && i_sfr_addr == 8'hd8 ##1 i_sfr_addr == 8'hd8
        |=> o_sfr_rdata[7] == $past(i_sfr_wdata[7], 2)) else $error("source not stored");
    a_pri_bit_hold: assert property ($fell(o_primary_txd) |-> !o_primary_txd [*8])
        else $error("short low bit");
    a_opt_bit_hold: assert property ($rose(o_optical_txd) |-> o_optical_txd [*8])
        else $error("short high bit");
endmodule
bind dsp_serial_pair dsp_pair_props i_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr_wr(i_sfr_wr),
    .i_timer_one_overflow(i_timer_one_overflow), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_primary_rxd(i_primary_rxd), .o_primary_txd(o_primary_txd),
    .i_optical_rxd(i_optical_rxd), .o_optical_txd(o_optical_txd));

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial port pair
`timescale 1ns/1ps
module tb_top;
    reg clk, rst_n, wr_en;
    reg [7:0] addr, wdata, d, t, v;
    reg [1:0] ovc;
    reg [9:0] got;
    reg [15:0] rb;
    wire [7:0] rdata;
    wire prx, ptx, orx, otx;
    integer n_fail, checked, k;
    dsp_serial_pair i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
        .i_sfr_wr(wr_en), .o_sfr_rdata(rdata), .i_timer_one_overflow(ovc == 2'h0), .i_primary_rxd(prx),
        .o_primary_txd(ptx), .i_optical_rxd(orx), .o_optical_txd(otx));
    dsp_host_model i_pri (.i_line(ptx), .o_line(prx));
    dsp_host_model i_opt (.i_line(otx), .o_line(orx));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Timer overflow every fourth cycle
    always @(negedge clk)
        ovc <= ovc + 2'h1;
    task chk(input [9:0] s, input [9:0] e);
        begin
            checked = checked + 1;
            if (s !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] w);
        begin
            @(negedge clk);
            addr = a;
            wdata = w;
            wr_en = 1'b1;
            @(negedge clk);
            wr_en = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(negedge clk);
            addr = a;
            @(negedge clk);
            v = rdata;
        end
    endtask
    // One frame each way; model gives flags, ninth bit and bit time
    task frame(input dbl, input src, input opt, input [7:0] c, input b9, input stp);
        reg nine, ok, e9;
        reg [7:0] b;
        integer per;
        begin
            b = opt ? 8'h9b : 8'h98;
            nine = opt ^ c[7];
            ok = c[4] & stp & (!c[5] | !nine | b9);
            e9 = ok ? (nine ? b9 : stp) : 1'b0;
            per = (opt | dbl ? 128 : 256) * (!opt & !src & c[7:6] != 2'b10 ? 2 : 1);
            wr(8'h87, {dbl, 7'h00});
            wr(8'hd8, {src, 7'h00});
            wr(b, c);
            d = $urandom;
            t = $urandom;
            wr(b + 8'h01, t);
            fork
                if (opt)
                    i_opt.recv(nine, per, got);
                else
                    i_pri.recv(nine, per, got);
                if (opt)
                    i_opt.send(d, b9, nine, stp, per);
                else
                    i_pri.send(d, b9, nine, stp, per);
            join
            chk(got, nine ? {1'b1, c[3], t} : {2'b01, t});
            repeat (40) @(negedge clk);
            rd(b);
            chk(v[2:0], {e9, 1'b1, ok});
            wr(b, v | 8'h03);
            rd(b);
            chk(v[2:0], {e9, 1'b1, ok});
            wr(b, v & 8'hfe);
            rd(b);
            chk(v[2:0], {e9, 2'b10});
            rd(b + 8'h01);
            if (ok)
                rb[opt*8 +: 8] = d;
            chk(v, rb[opt*8 +: 8]);
        end
    endtask
    task end_of_test;
        begin
            $display("%0d checks %0d fails", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        {n_fail, checked, ovc, rst_n, wr_en, addr, wdata, rb} = 0;
        k = $urandom(32'h397f479d);
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h98);
        chk(v, 8'h00);
        wr(8'h01, 8'hff);
        rd(8'h01);
        chk(v, 8'h00);
        wr(8'haa, 8'hff);
        wr(8'hba, 8'h03);
        wr(8'h9d, 8'hff);
        wr(8'h9e, 8'h03);
        // Generators count up from zero once before the first reload
        repeat (4100) @(negedge clk);
        frame(0, 1, 0, 8'h50, 1'b0, 1'b1);
        frame(0, 1, 0, 8'hd8, 1'b0, 1'b1);
        frame(0, 1, 0, 8'hf0, 1'b0, 1'b1);
        frame(0, 1, 0, 8'hf8, 1'b1, 1'b1);
        frame(0, 1, 0, 8'h50, 1'b1, 1'b0);
        frame(0, 1, 0, 8'h40, 1'b1, 1'b1);
        frame(1, 1, 0, 8'h50, 1'b0, 1'b1);
        frame(1, 1, 0, 8'h90, 1'b1, 1'b1);
        frame(0, 0, 0, 8'h50, 1'b0, 1'b1);
        frame(0, 1, 1, 8'h90, 1'b0, 1'b1);
        frame(1, 1, 1, 8'h18, 1'b1, 1'b1);
        wr(8'h98, 8'h10);
        wr(8'h99, 8'h00);
        repeat (100) @(negedge clk);
        chk(ptx, 1'b1);
        rd(8'h98);
        chk(v[1:0], 2'b00);
        end_of_test;
    end
endmodule
